// [design/io_port_pkg.sv]
package io_port_pkg;

  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADDR_W = 16;

  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_DATA = 16'hffd8;
  localparam logic [ADDR_W-1:0] ADDR_DIRECTION = 16'hffe8;
  localparam logic [ADDR_W-1:0] ADDR_PULLUP_ENABLE = 16'hffef;

  // reset and fixed read values
  localparam logic [PORT_W-1:0] RESET_OUTPUT_DATA = 8'h00;
  localparam logic [PORT_W-1:0] RESET_DIRECTION = 8'h00;
  localparam logic [PORT_W-1:0] RESET_PULLUP_ENABLE = 8'h00;
  localparam logic [PORT_W-1:0] DIRECTION_READ_VALUE = 8'hff;
  localparam logic [PORT_W-1:0] UNMAPPED_READ_VALUE = 8'h00;
  localparam logic [PORT_W-1:0] IDLE_READ_VALUE = 8'h00;
  localparam logic [PORT_W-1:0] ALL_RELEASED = 8'hff;
  localparam logic [PORT_W-1:0] ALL_LOW = 8'h00;

  // pins with extra consumers
  localparam int unsigned TIMER_B_PIN = 6;
  localparam int unsigned CONV_TRIG_PIN = 5;

  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'b000,
    MODE_SUBACTIVE = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_SUBSLEEP = 3'b011,
    MODE_STANDBY = 3'b100,
    MODE_WATCH = 3'b101
  } power_mode_t;

endpackage

// [design/pin_ctrl_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface pin_ctrl_if;
  import io_port_pkg::*;

  logic [PORT_W-1:0] direction;
  logic [PORT_W-1:0] out_data;
  logic [PORT_W-1:0] pullup_en;
  logic hold;
  logic release_all;
  logic [PORT_W-1:0] pin_out;
  logic [PORT_W-1:0] pin_oe_n;
  logic [PORT_W-1:0] pullup_on;

  modport regs (
    output direction, out_data, pullup_en, hold, release_all,
    input pin_out, pin_oe_n, pullup_on
  );

  modport stage (
    input direction, out_data, pullup_en, hold, release_all,
    output pin_out, pin_oe_n, pullup_on
  );
endinterface
`default_nettype wire

// [design/pin_drive_stage.sv]
`timescale 1ns/100ps
`default_nettype none
module pin_drive_stage
  import io_port_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  pin_ctrl_if.stage ctl
);

  logic [PORT_W-1:0] oe_n_q;
  logic [PORT_W-1:0] oe_n_d;
  logic [PORT_W-1:0] out_q;
  logic [PORT_W-1:0] out_d;
  logic [PORT_W-1:0] pu_q;
  logic [PORT_W-1:0] pu_d;

  genvar i;
  generate
    for (i = 0; i < PORT_W; i++) begin : g_pin
      // sleep freezes the whole stage; standby floats the driver only
      assign oe_n_d[i] = ctl.hold ? oe_n_q[i] :
                         (ctl.release_all ? 1'b1 : ~ctl.direction[i]);
      assign out_d[i] = ctl.hold ? out_q[i] : ctl.out_data[i];
      // pull-up only on an input pin with its enable set
      assign pu_d[i] = ctl.hold ? pu_q[i] :
                       (~ctl.direction[i] & ctl.pullup_en[i]);
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      oe_n_q <= ALL_RELEASED;
      out_q <= ALL_LOW;
      pu_q <= ALL_LOW;
    end else begin
      oe_n_q <= oe_n_d;
      out_q <= out_d;
      pu_q <= pu_d;
    end
  end

  assign ctl.pin_oe_n = oe_n_q;
  assign ctl.pin_out = out_q;
  assign ctl.pullup_on = pu_q;

endmodule // pin_drive_stage
`default_nettype wire

// [design/eight_bit_io_port_pullup.sv]
// The strobed register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - output data register, read/write, resets zero
// - direction 1: read returns stored data bit
// - direction 0: read returns sampled pin level
// - direction bit 1 drives pin, 0 inputs
// - direction register resets to all inputs
// - direction register write-only, reads all ones
// - pull-up on only for input with enable
// - clearing enable bit turns pull-up off
// - pull-up enable register read/write, resets zero
// - all pull-ups off right after reset
// - every pin feeds its interrupt line always
// - pin 6 also feeds timer input B
// - reset/standby/watch float, sleep/subsleep hold, else functional
module eight_bit_io_port_pullup
  import io_port_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [PORT_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [PORT_W-1:0] reg_rdata_o,
  input wire logic [2:0] power_mode_i,
  input wire logic [PORT_W-1:0] port_pin_i,
  output logic [PORT_W-1:0] port_pin_o,
  output logic [PORT_W-1:0] port_pin_oe_n_o,
  output logic [PORT_W-1:0] pullup_on_o,
  output logic [PORT_W-1:0] external_interrupt_line_o,
  output logic timer_external_input_b_o,
  output logic converter_external_trigger_o
);

  logic [PORT_W-1:0] port_output_data_q;
  logic [PORT_W-1:0] port_direction_q;
  logic [PORT_W-1:0] port_pullup_enable_q;
  logic [PORT_W-1:0] rdata_q;
  logic [PORT_W-1:0] rdata_d;
  logic hold;
  logic release_all;
  power_mode_t mode;

  pin_ctrl_if ctl ();

  // address decode
  wire sel_data = (reg_addr_i == ADDR_OUTPUT_DATA);
  wire sel_dir = (reg_addr_i == ADDR_DIRECTION);
  wire sel_pull = (reg_addr_i == ADDR_PULLUP_ENABLE);
  wire wr_data = reg_wr_i & sel_data;
  wire wr_dir = reg_wr_i & sel_dir;
  wire wr_pull = reg_wr_i & sel_pull;

  // per-bit mux: driven pins read back the latch, not the pad,
  // so a loaded output cannot corrupt read-modify-write
  wire [PORT_W-1:0] port_read =
    (port_direction_q & port_output_data_q) |
    (~port_direction_q & port_pin_i);

  assign rdata_d = !reg_rd_i ? IDLE_READ_VALUE :
                   sel_data ? port_read :
                   sel_dir ? DIRECTION_READ_VALUE :
                   sel_pull ? port_pullup_enable_q :
                   UNMAPPED_READ_VALUE;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      port_output_data_q <= RESET_OUTPUT_DATA;
    end else if (wr_data) begin
      port_output_data_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      port_direction_q <= RESET_DIRECTION;
    end else if (wr_dir) begin
      port_direction_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      port_pullup_enable_q <= RESET_PULLUP_ENABLE;
    end else if (wr_pull) begin
      port_pullup_enable_q <= reg_wdata_i;
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= IDLE_READ_VALUE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign mode = power_mode_t'(power_mode_i);

  // unlisted mode codes fall back to normal operation
  always_comb begin
    hold = 1'b0;
    release_all = 1'b0;
    unique case (mode)
      MODE_ACTIVE, MODE_SUBACTIVE: begin
        hold = 1'b0;
      end
      MODE_SLEEP, MODE_SUBSLEEP: begin
        hold = 1'b1;
      end
      MODE_STANDBY, MODE_WATCH: begin
        release_all = 1'b1;
      end
      default: begin
        hold = 1'b0;
      end
    endcase
  end

  assign ctl.direction = port_direction_q;
  assign ctl.out_data = port_output_data_q;
  assign ctl.pullup_en = port_pullup_enable_q;
  assign ctl.hold = hold;
  assign ctl.release_all = release_all;

  pin_drive_stage u_stage (
    .core_clk_i (core_clk_i),
    .sys_rst_i (sys_rst_i),
    .ctl (ctl.stage)
  );

  assign reg_rdata_o = rdata_q;
  assign port_pin_o = ctl.pin_out;
  assign port_pin_oe_n_o = ctl.pin_oe_n;
  assign pullup_on_o = ctl.pullup_on;

  // inputs reach their consumers regardless of direction
  assign external_interrupt_line_o = port_pin_i;
  assign timer_external_input_b_o = port_pin_i[TIMER_B_PIN];
  assign converter_external_trigger_o = port_pin_i[CONV_TRIG_PIN];

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  wire functional = (mode == MODE_ACTIVE) || (mode == MODE_SUBACTIVE);
  wire sleeping = (mode == MODE_SLEEP) || (mode == MODE_SUBSLEEP);
  wire parked = (mode == MODE_STANDBY) || (mode == MODE_WATCH);

  sequence s_data_written;
    reg_wr_i && sel_data;
  endsequence

  sequence s_pull_cleared;
    reg_wr_i && sel_pull && (reg_wdata_i == ALL_LOW);
  endsequence

  sequence s_running_two;
    functional ##1 functional;
  endsequence

  sequence s_asleep_two;
    sleeping ##1 sleeping;
  endsequence

  a_data_write: assert property (
    s_data_written |=> port_output_data_q == $past(reg_wdata_i)
  ) else $error("output data register missed a write");

  a_data_keeps: assert property (
    !wr_data |=> port_output_data_q == $past(port_output_data_q)
  ) else $error("output data register changed without a write");

  a_read_driven: assert property (
    (reg_rd_i && sel_data) |=>
      ((reg_rdata_o & $past(port_direction_q)) ==
       ($past(port_output_data_q) & $past(port_direction_q)))
  ) else $error("driven pin read did not return stored data");

  a_read_input: assert property (
    (reg_rd_i && sel_data) |=>
      ((reg_rdata_o & ~$past(port_direction_q)) ==
       ($past(port_pin_i) & ~$past(port_direction_q)))
  ) else $error("input pin read did not return pin level");

  a_dir_drives: assert property (
    s_running_two |-> port_pin_oe_n_o == ~$past(port_direction_q)
  ) else $error("pin drive does not follow direction");

  a_out_follows: assert property (
    s_running_two |-> port_pin_o == $past(port_output_data_q)
  ) else $error("pin output does not follow stored data");

  a_reset_clears: assert property (
    $fell(sys_rst_i) |-> port_direction_q == RESET_DIRECTION &&
      port_output_data_q == RESET_OUTPUT_DATA
  ) else $error("registers not cleared by reset");

  a_dir_reads_ones: assert property (
    (reg_rd_i && sel_dir) |=> reg_rdata_o == DIRECTION_READ_VALUE
  ) else $error("direction register did not read all ones");

  a_pullup_gate: assert property (
    s_running_two |->
      pullup_on_o == (~$past(port_direction_q) & $past(port_pullup_enable_q))
  ) else $error("pull-up not gated by direction and enable");

  a_pullup_clear: assert property (
    (s_pull_cleared ##1 functional) |=> pullup_on_o == ALL_LOW
  ) else $error("clearing enable left a pull-up on");

  a_pull_readback: assert property (
    (reg_wr_i && sel_pull) ##1 (reg_rd_i && sel_pull) |=>
      reg_rdata_o == $past(reg_wdata_i, 2)
  ) else $error("pull-up enable did not read back");

  a_pull_after_reset: assert property (
    $fell(sys_rst_i) |-> pullup_on_o == ALL_LOW &&
      port_pullup_enable_q == RESET_PULLUP_ENABLE
  ) else $error("pull-up on right after reset");

  a_reset_floats: assert property (
    @(posedge core_clk_i) disable iff (1'b0)
    sys_rst_i |=> port_pin_oe_n_o == ALL_RELEASED
  ) else $error("pins driven during reset");

  a_irq_route: assert property (
    external_interrupt_line_o == port_pin_i
  ) else $error("interrupt lines do not follow pins");

  a_timer_route: assert property (
    timer_external_input_b_o == port_pin_i[TIMER_B_PIN]
  ) else $error("timer input B does not follow its pin");

  a_trig_route: assert property (
    converter_external_trigger_o == port_pin_i[CONV_TRIG_PIN]
  ) else $error("converter trigger does not follow its pin");

  a_sleep_holds: assert property (
    s_asleep_two |-> $stable(port_pin_oe_n_o) && $stable(port_pin_o) &&
      $stable(pullup_on_o)
  ) else $error("pins changed while asleep");

  a_parked_floats: assert property (
    parked |=> port_pin_oe_n_o == ALL_RELEASED
  ) else $error("pins driven in standby or watch");

  a_parked_pullup: assert property (
    parked ##1 parked |->
      pullup_on_o == (~$past(port_direction_q) & $past(port_pullup_enable_q))
  ) else $error("pull-up lost in standby or watch");

  a_idle_read: assert property (
    !reg_rd_i |=> reg_rdata_o == IDLE_READ_VALUE
  ) else $error("read data stood beyond its cycle");

  a_dir_write: assert property (
    (reg_wr_i && sel_dir) |=> port_direction_q == $past(reg_wdata_i)
  ) else $error("direction register missed a write");

  a_dir_keeps: assert property (
    !wr_dir |=> port_direction_q == $past(port_direction_q)
  ) else $error("direction register changed without a write");

  a_pull_write: assert property (
    (reg_wr_i && sel_pull) |=> port_pullup_enable_q == $past(reg_wdata_i)
  ) else $error("pull-up enable register missed a write");

  a_pull_keeps: assert property (
    !wr_pull |=> port_pullup_enable_q == $past(port_pullup_enable_q)
  ) else $error("pull-up enable register changed without a write");

  a_reset_regs: assert property (
    @(posedge core_clk_i) disable iff (1'b0)
    sys_rst_i |=> port_direction_q == RESET_DIRECTION && port_output_data_q == RESET_OUTPUT_DATA
  ) else $error("registers not held clear in reset");

  a_reset_pull_reg: assert property (
    @(posedge core_clk_i) disable iff (1'b0)
    sys_rst_i |=> port_pullup_enable_q == RESET_PULLUP_ENABLE
  ) else $error("pull-up enable not held clear in reset");

  a_reset_quiet: assert property (
    @(posedge core_clk_i) disable iff (1'b0)
    sys_rst_i |=> port_pin_o == ALL_LOW && pullup_on_o == ALL_LOW
  ) else $error("pin output or pull-up active in reset");

  // freeze must start on the first sleeping edge, not one later
  sequence s_enter_sleep;
    functional ##1 sleeping;
  endsequence

  a_sleep_entry: assert property (
    s_enter_sleep |=> $stable(port_pin_oe_n_o) && $stable(port_pin_o) && $stable(pullup_on_o)
  ) else $error("pins moved on entering sleep");

  a_driven_no_pull: assert property (
    s_running_two |-> (pullup_on_o & $past(port_direction_q)) == ALL_LOW
  ) else $error("pull-up on for a driven pin");

  a_parked_latch: assert property (
    parked ##1 parked |-> port_pin_o == $past(port_output_data_q)
  ) else $error("output latch stopped tracking in standby or watch");

endmodule // eight_bit_io_port_pullup
`default_nettype wire

// [testbench/pin_board_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pin_board_model
  import io_port_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic [PORT_W-1:0] drive_i,
  input wire logic [PORT_W-1:0] oe_n_i,
  input wire logic [PORT_W-1:0] pullup_i,
  input wire logic [PORT_W-1:0] ext_en_i,
  input wire logic [PORT_W-1:0] ext_val_i,
  output logic [PORT_W-1:0] level_o
);
  // undriven pins with neither a board drive nor a pull-up toggle so a stale level never passes for a real one
  logic [PORT_W-1:0] float_q = 8'h5a;
  wire logic [PORT_W-1:0] by_port = ~oe_n_i & drive_i;
  wire logic [PORT_W-1:0] by_board = oe_n_i & ext_en_i & ext_val_i;
  wire logic [PORT_W-1:0] by_float = oe_n_i & ~ext_en_i & (pullup_i | float_q);
  always_ff @(posedge core_clk_i) begin
    float_q <= ~float_q;
  end
  assign level_o = by_port | by_board | by_float;
endmodule // pin_board_model
`default_nettype wire

// [testbench/eight_bit_io_port_pullup_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module eight_bit_io_port_pullup_tb import io_port_pkg::*; ;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [ADDR_W-1:0] reg_addr_i = 16'h0000;
  logic [PORT_W-1:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [2:0] power_mode_i = 3'h0;
  logic [PORT_W-1:0] ext_en = 8'hff;
  logic [PORT_W-1:0] ext_val = 8'h3c;
  logic [PORT_W-1:0] rdata, level, pin_o, oe_n, pu_on, irq, lvl;
  logic tmr, trig;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [7:0] pats [4] = '{8'h00, 8'hff, 8'h40, 8'ha0};
  // per mode code 0 to 7; spare codes 6 and 7 behave as active
  logic [7:0] exp_oe [8] = '{8'h0f, 8'h0f, 8'hf0, 8'hf0, 8'hff, 8'hff, 8'h0f, 8'h0f};
  logic [7:0] exp_pu [8] = '{8'h0f, 8'h0f, 8'hf0, 8'hf0, 8'h0f, 8'h0f, 8'h0f, 8'h0f};

  eight_bit_io_port_pullup uut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(rdata), .power_mode_i(power_mode_i), .port_pin_i(level),
    .port_pin_o(pin_o), .port_pin_oe_n_o(oe_n), .pullup_on_o(pu_on),
    .external_interrupt_line_o(irq), .timer_external_input_b_o(tmr),
    .converter_external_trigger_o(trig)
  );

  pin_board_model board (
    .core_clk_i(core_clk_i), .drive_i(pin_o), .oe_n_i(oe_n), .pullup_i(pu_on),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(level)
  );

  always #10 core_clk_i = ~core_clk_i;

  task automatic finish_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // generous ceiling: the whole sequence needs well under 1000 cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(rdata, e);
  endtask

  // write then read back with no gap between the strobes
  task automatic wr_rd(input logic [15:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(rdata, e);
  endtask

  // pins follow a register one edge after it changes
  task automatic settle;
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask

  initial begin
    repeat (20) @(posedge core_clk_i);
    #1 chk(oe_n, 8'hff);
    chk(pu_on, 8'h00);
    @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rd(ADDR_DIRECTION, 8'hff);
    rd(ADDR_PULLUP_ENABLE, 8'h00);
    rd(ADDR_OUTPUT_DATA, 8'h3c);
    wr(ADDR_OUTPUT_DATA, 8'ha5);
    wr(ADDR_DIRECTION, 8'h0f);
    wr(16'hffd9, 8'hff);
    rd(16'hffd9, 8'h00);
    settle();
    chk(oe_n, 8'hf0);
    chk(pin_o & 8'h0f, 8'h05);
    rd(ADDR_OUTPUT_DATA, 8'h35);
    rd(ADDR_DIRECTION, 8'hff);
    wr(ADDR_PULLUP_ENABLE, 8'hff);
    settle();
    chk(pu_on, 8'hf0);
    rd(ADDR_PULLUP_ENABLE, 8'hff);
    @(posedge core_clk_i);
    ext_en <= 8'h00;
    #1 chk(irq, 8'hf5);
    @(posedge core_clk_i);
    ext_en <= 8'hff;
    wr(ADDR_PULLUP_ENABLE, 8'h0f);
    settle();
    chk(pu_on, 8'h00);
    wr_rd(ADDR_PULLUP_ENABLE, 8'hff, 8'hff);
    settle();
    chk(pu_on, 8'hf0);
    wr_rd(ADDR_PULLUP_ENABLE, 8'h00, 8'h00);
    settle();
    chk(pu_on, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_i);
      ext_val <= pats[i];
      #1 lvl = 8'h05 | (pats[i] & 8'hf0);
      chk(irq, lvl);
      chk({7'h00, tmr}, {7'h00, lvl[TIMER_B_PIN]});
      chk({7'h00, trig}, {7'h00, lvl[CONV_TRIG_PIN]});
      rd(ADDR_OUTPUT_DATA, lvl);
    end
    for (int m = 0; m < 8; m++) begin
      @(posedge core_clk_i);
      power_mode_i <= MODE_ACTIVE;
      wr(ADDR_DIRECTION, 8'h0f);
      wr(ADDR_PULLUP_ENABLE, 8'hff);
      settle();
      @(posedge core_clk_i);
      power_mode_i <= m[2:0];
      wr(ADDR_DIRECTION, 8'hf0);
      settle();
      chk(oe_n, exp_oe[m]);
      chk(pu_on, exp_pu[m]);
    end
    @(posedge core_clk_i);
    power_mode_i <= MODE_ACTIVE;
    sys_rst_i <= 1'b1;
    settle();
    chk(oe_n, 8'hff);
    chk(pu_on, 8'h00);
    @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rd(ADDR_PULLUP_ENABLE, 8'h00);
    wr(ADDR_DIRECTION, 8'hff);
    rd(ADDR_OUTPUT_DATA, 8'h00);
    finish_test();
  end
endmodule // eight_bit_io_port_pullup_tb
`default_nettype wire
